// file: verilog/efi_pkg.sv
/*
  Constants for the event filter interrupter: backplane offsets, address
  modifier codes, status bit positions, reset values and the bus state set.
  Assumes a 24-bit backplane address space with byte-wide odd-lane registers.
*/
package efi_pkg;

  // Accepted address modifiers
  localparam logic [5:0]  AM_SUPER      = 6'h3D;
  localparam logic [5:0]  AM_USER       = 6'h39;

  // Byte offsets inside the board map (A13..A0, odd lane)
  localparam logic [13:0] OFS_ROUTE     = 14'h0041;
  localparam logic [13:0] OFS_FSTAT     = 14'h0055;
  localparam logic [13:0] OFS_STATUS    = 14'h005D;
  localparam logic [13:0] OFS_VECTOR    = 14'h0065;
  localparam logic [13:0] OFS_FCLEAR    = 14'h006D;
  localparam logic [4:0]  FILT_PAGE     = 5'h04;

  // Queue status byte layout
  localparam int          FST_EMPTY_N   = 5;
  localparam int          FST_FULL_N    = 4;
  localparam int          FST_ERR       = 0;

  // Values after reset
  localparam logic [2:0]  ROUTE_RST     = 3'h0;
  localparam logic [7:0]  VECTOR_RST    = 8'h00;

  // Widths fixed by the backplane and the event code
  localparam int          BASE_W        = 10;
  localparam int          CODE_W        = 8;
  localparam int          CODES         = 256;
  localparam int          IRQ_LEVELS    = 7;

  // Backplane cycle states
  typedef enum logic [1:0]
  {
    EFI_IDLE = 2'b01,
    EFI_ACK  = 2'b10
  } efi_state_t;

endpackage : efi_pkg

// file: verilog/efi_filter_irq.sv
/*
  Event filter interrupter: a backplane A24 slave port, a 256-entry enable
  table, a queue of enabled event codes and one routed interrupt request.
  Assumes backplane pins are asynchronous to mclk_i and are synchronised here;
  event strobe and code come from a link receiver on the same clock.
*/
// Contract
// - Only A24 cycles carrying modifier 3D or 39 are answered; the master must drive one of them.
// - The board selects itself when A23-A14 equal the jumper base, lower lines give the offset.
// - Word and odd-byte cycles are served fully, even-byte cycles only get a zero read and no write.
// - An acknowledge cycle is answered as a single-level odd-byte interrupter with a byte on D00-D07.
// - The request stays up through the acknowledge and drops only when the status register is read.
// - Received event codes address a table of 256 entries.
// - An entry holding 1 makes its code an interrupt-generating event.
// - One software-written vector is returned for every event interrupt.
// - Reading the status register returns the code at the head of the queue.
// - Enabled codes go into one 16-entry queue and are read back in arrival order.
// - A code whose entry holds 0 is ignored entirely.
// - Only a code entering an empty queue raises the request; software must drain the queue.
// - A full queue drops new codes and latches an error flag that clears on read.
// - A three-bit route picks level 1-7, zero disables, and reset clears it.
module efi_filter_irq #(
  parameter int DEPTH = 16
) (
  input  wire logic                         mclk_i,
  input  wire logic                         rst_i,
  input  wire logic [efi_pkg::BASE_W-1:0]   base_jmp_i,
  input  wire logic [23:1]                  addr_i,
  input  wire logic [5:0]                   am_i,
  input  wire logic                         as_n_i,
  input  wire logic [1:0]                   ds_n_i,
  input  wire logic                         write_n_i,
  input  wire logic                         iack_n_i,
  input  wire logic                         iackin_n_i,
  input  wire logic [15:0]                  data_i,
  output logic      [15:0]                  data_o,
  output logic                              data_oe_o,
  output logic                              dtack_o,
  output logic                              dtack_oe_o,
  output logic                              iackout_n_o,
  output logic      [efi_pkg::IRQ_LEVELS:1] irq_o,
  output logic      [efi_pkg::IRQ_LEVELS:1] irq_oe_o,
  input  wire logic                         ev_stb_i,
  input  wire logic [efi_pkg::CODE_W-1:0]   ev_code_i
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = efi_pkg::BASE_W + 16 + 23 + 6 + 6;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  // Pointers wrap by overflow, so only powers of two are served
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_depth_chk
    $error("DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [PW-1:0]                          s1;
    logic [PW-1:0]                          s2;
    efi_pkg::efi_state_t                    st;
    logic [efi_pkg::CODES-1:0]              filt;
    logic [DEPTH-1:0][efi_pkg::CODE_W-1:0]  mem;
    logic [AW-1:0]                          rd;
    logic [AW-1:0]                          wr;
    logic [AW:0]                            cnt;
    logic [7:0]                             vec;
    logic [2:0]                             route;
    logic                                   pend;
    logic                                   ferr;
    logic [7:0]                             rdat;
    logic                                   dtack;
    logic                                   drive;
    logic                                   pass;
  } efi_regs_t;

  efi_regs_t q_reg;
  efi_regs_t q_next;

  // Synchronised pin view
  logic                        as_n;
  logic [1:0]                  ds_n;
  logic                        wr_n;
  logic                        iack_n;
  logic                        iackin_n;
  logic [5:0]                  am;
  logic [23:1]                 addr;
  logic [15:0]                 dat;
  logic [efi_pkg::BASE_W-1:0]  base;
  logic [13:0]                 off;

  assign {base, dat, addr, am, iackin_n, iack_n, wr_n, ds_n, as_n} = q_reg.s2;
  assign off = {addr[13:1], 1'b1};

  logic       cyc;
  logic       am_ok;
  logic       bus_sel;
  logic       iack_cyc;
  logic       ours;
  logic       acc;
  logic       rd_acc;
  logic       wr_acc;
  logic       stat_rd;
  logic       fst_rd;
  logic       fclr;
  logic       pop;
  logic       hit;
  logic       push;
  logic       drop;
  logic [7:0] head;
  logic [7:0] rd_val;

  assign cyc      = q_reg.st == efi_pkg::EFI_IDLE && !as_n && ds_n != 2'b11;
  assign am_ok    = am == efi_pkg::AM_SUPER || am == efi_pkg::AM_USER;
  assign bus_sel  = iack_n && am_ok && addr[23:14] == base;
  assign iack_cyc = !iack_n && !iackin_n && !ds_n[0];
  assign ours     = q_reg.pend && q_reg.route != 3'h0 && addr[3:1] == q_reg.route;
  assign acc      = cyc && bus_sel;
  // Even-byte cycles are answered but touch nothing
  assign rd_acc   = acc && wr_n && !ds_n[0];
  assign wr_acc   = acc && !wr_n && !ds_n[0];
  assign stat_rd  = rd_acc && off == efi_pkg::OFS_STATUS;
  assign fst_rd   = rd_acc && off == efi_pkg::OFS_FSTAT;
  assign fclr     = rd_acc && off == efi_pkg::OFS_FCLEAR;
  assign pop      = stat_rd && q_reg.cnt != '0;
  assign head     = q_reg.cnt != '0 ? q_reg.mem[q_reg.rd] : 8'h00;
  assign hit      = ev_stb_i && q_reg.filt[ev_code_i];

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    rd_val = 8'h00;
    if (ds_n[0])
      rd_val = 8'h00;
    else if (off == efi_pkg::OFS_ROUTE)
      rd_val = {5'h00, q_reg.route};
    else if (off == efi_pkg::OFS_VECTOR)
      rd_val = q_reg.vec;
    else if (off == efi_pkg::OFS_STATUS)
      rd_val = head;
    else if (off == efi_pkg::OFS_FSTAT)
    begin
      rd_val[efi_pkg::FST_EMPTY_N] = q_reg.cnt != '0;
      rd_val[efi_pkg::FST_FULL_N]  = q_reg.cnt != FULL;
      rd_val[efi_pkg::FST_ERR]     = q_reg.ferr;
    end
    else if (off[13:9] == efi_pkg::FILT_PAGE)
      rd_val = {7'h00, q_reg.filt[off[8:1]]};
  end

  always_comb
  begin
    logic [AW-1:0] rd_b;
    logic [AW-1:0] wr_b;
    logic [AW:0]   cnt_b;
    rd_b   = '0;
    wr_b   = '0;
    cnt_b  = '0;
    q_next = q_reg;
    push   = 1'b0;
    drop   = 1'b0;
    q_next.s1 = {base_jmp_i, data_i, addr_i, am_i, iackin_n_i, iack_n_i, write_n_i, ds_n_i, as_n_i};
    q_next.s2 = q_reg.s1;

    case (q_reg.st)
      efi_pkg::EFI_IDLE:
      begin
        q_next.dtack = 1'b0;
        q_next.drive = 1'b0;
        q_next.pass  = 1'b0;
        if (acc)
        begin
          q_next.st    = efi_pkg::EFI_ACK;
          q_next.dtack = 1'b1;
          q_next.drive = wr_n;
          q_next.rdat  = rd_val;
        end
        else if (cyc && iack_cyc)
        begin
          q_next.st = efi_pkg::EFI_ACK;
          if (ours)
          begin
            q_next.dtack = 1'b1;
            q_next.drive = 1'b1;
            q_next.rdat  = q_reg.vec;
          end
          else
            q_next.pass = 1'b1;
        end
      end
      efi_pkg::EFI_ACK:
      begin
        if (as_n && ds_n == 2'b11)
        begin
          q_next.st    = efi_pkg::EFI_IDLE;
          q_next.dtack = 1'b0;
          q_next.drive = 1'b0;
          q_next.pass  = 1'b0;
        end
      end
      default:
      begin
        q_next.st = efi_pkg::EFI_IDLE;
      end
    endcase

    if (wr_acc)
    begin
      if (off == efi_pkg::OFS_ROUTE)
        q_next.route = dat[2:0];
      else if (off == efi_pkg::OFS_VECTOR)
        q_next.vec = dat[7:0];
      else if (off[13:9] == efi_pkg::FILT_PAGE)
        q_next.filt[off[8:1]] = dat[0];
    end

    // Queue clear first, so an event in the same cycle lands in the fresh queue
    if (fclr)
    begin
      rd_b  = '0;
      wr_b  = '0;
      cnt_b = '0;
    end
    else
    begin
      rd_b  = q_reg.rd + AW'(pop);
      wr_b  = q_reg.wr;
      cnt_b = q_reg.cnt - (AW+1)'(pop);
    end
    push = hit && cnt_b != FULL;
    drop = hit && cnt_b == FULL;
    if (push)
    begin
      q_next.mem[wr_b] = ev_code_i;
      wr_b  = wr_b + AW'(1);
      cnt_b = cnt_b + (AW+1)'(1);
    end
    q_next.rd  = rd_b;
    q_next.wr  = wr_b;
    q_next.cnt = cnt_b;

    // Set wins over the clearing read in both flags
    q_next.pend = (q_reg.pend && !stat_rd) || (push && cnt_b == (AW+1)'(1));
    q_next.ferr = (q_reg.ferr && !fst_rd) || drop;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      q_reg       <= '0;
      q_reg.st    <= efi_pkg::EFI_IDLE;
      q_reg.s1    <= '1;
      q_reg.s2    <= '1;
      q_reg.route <= efi_pkg::ROUTE_RST;
      q_reg.vec   <= efi_pkg::VECTOR_RST;
    end
    else
      q_reg <= q_next;
  end

  // Open-drain lines are only ever pulled low
  assign data_o      = {8'h00, q_reg.rdat};
  assign data_oe_o   = q_reg.drive;
  assign dtack_o     = 1'b0;
  assign dtack_oe_o  = q_reg.dtack;
  assign iackout_n_o = !q_reg.pass;
  assign irq_o       = '0;

  for (genvar l = 1; l <= efi_pkg::IRQ_LEVELS; l++)
  begin : g_route
    assign irq_oe_o[l] = q_reg.pend && q_reg.route == 3'(l);
  end

  a_am_reject: assert property (@(posedge mclk_i) disable iff (rst_i)
    cyc && iack_n && !am_ok |=> !dtack_oe_o)
    else $error("cycle with foreign modifier answered");

  a_base_select: assert property (@(posedge mclk_i) disable iff (rst_i)
    cyc && am_ok && iack_n && addr[23:14] == base |=> dtack_oe_o)
    else $error("selected cycle not acknowledged");

  a_even_lane: assert property (@(posedge mclk_i) disable iff (rst_i)
    cyc && bus_sel && ds_n == 2'b01 |=> dtack_oe_o && data_o == 16'h0000)
    else $error("even byte read not answered with zero");

  a_iack_vector: assert property (@(posedge mclk_i) disable iff (rst_i)
    cyc && iack_cyc && ours |=> dtack_oe_o && data_oe_o && data_o[7:0] == $past(q_reg.vec))
    else $error("acknowledge did not return vector");

  a_irq_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    q_reg.pend && !stat_rd |=> q_reg.pend)
    else $error("request dropped without status read");

  a_status_code: assert property (@(posedge mclk_i) disable iff (rst_i)
    stat_rd |=> data_o[7:0] == $past(head) ##1 data_oe_o)
    else $error("status read returned wrong code");

  a_fifo_push: assert property (@(posedge mclk_i) disable iff (rst_i)
    hit && !pop && !fclr && q_reg.cnt != FULL
    |=> q_reg.cnt == $past(q_reg.cnt) + (AW+1)'(1) && q_reg.mem[$past(q_reg.wr)] == $past(ev_code_i))
    else $error("enabled code not queued");

  a_filter_drop: assert property (@(posedge mclk_i) disable iff (rst_i)
    ev_stb_i && !q_reg.filt[ev_code_i] && !pop && !fclr |=> $stable(q_reg.cnt))
    else $error("disabled code changed the queue");

  a_first_only: assert property (@(posedge mclk_i) disable iff (rst_i)
    !q_reg.pend && q_reg.cnt != '0 && !fclr && !(pop && q_reg.cnt == (AW+1)'(1)) |=> !q_reg.pend)
    else $error("request raised for non-empty queue");

  a_full_error: assert property (@(posedge mclk_i) disable iff (rst_i)
    hit && q_reg.cnt == FULL && !pop && !fclr |=> q_reg.ferr && q_reg.cnt == FULL)
    else $error("overflow not flagged");

  a_route_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    q_reg.route == 3'h0 |-> irq_oe_o == '0)
    else $error("request driven with routing disabled");

endmodule : efi_filter_irq

// file: test/efi_vme_master.sv
/*
  Backplane master model: A24 data and acknowledge cycles, one at a time.
  Assumes one caller process and that the bench feeds back the wire level.
*/
module efi_vme_master (
  input  wire logic        mclk_i,
  input  wire logic        dtack_oe_i,
  input  wire logic [15:0] data_i,
  output logic      [23:1] addr_o,
  output logic      [5:0]  am_o,
  output logic             as_n_o,
  output logic      [1:0]  ds_n_o,
  output logic             write_n_o,
  output logic             iack_n_o,
  output logic      [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    addr_o    = '0;
    am_o      = 6'h00;
    as_n_o    = 1'b1;
    ds_n_o    = 2'b11;
    write_n_o = 1'b1;
    iack_n_o  = 1'b1;
    data_o    = 16'h0000;
  end

  // Strobes held until DTACK; a silent board is abandoned after 12 edges
  task automatic cyc(input logic ack, input logic wr, input logic [1:0] ds, input logic [5:0] am,
                     input logic [23:1] a, input logic [7:0] wd, output logic [7:0] rd, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    @(negedge mclk_i);
    addr_o    = a;
    am_o      = am;
    iack_n_o  = !ack;
    write_n_o = !wr;
    data_o    = {8'h00, wd};
    as_n_o    = 1'b0;
    ds_n_o    = ds;
    while (!ok && n < 12)
    begin
      @(posedge mclk_i);
      ok = dtack_oe_i;
      n++;
    end
    rd = data_i[7:0];
    @(negedge mclk_i);
    as_n_o = 1'b1;
    ds_n_o = 2'b11;
    // Released lines flip so a stale value cannot pass
    data_o = ~data_o;
    addr_o = ~addr_o;
    n      = 0;
    while (dtack_oe_i && n < 12)
    begin
      @(posedge mclk_i);
      n++;
    end
  endtask : cyc

endmodule : efi_vme_master

// file: test/event_filter_interrupter_tb_top.sv
/*
  Bench for the event filter interrupter: register rows, then events,
  acknowledge, queue order, overflow, refusals and routing.
  Assumes queue depth 4 and jumper base 3C0.
*/
module event_filter_interrupter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed
  {
    logic        wr;
    logic [13:0] off;
    logic [7:0]  wd;
    logic [7:0]  ex;
  } efi_row_t;

  localparam logic [9:0] BASE = 10'h3C0;
  logic        mclk_i  = 1'b0;
  logic        rst_i   = 1'b1;
  logic        ev_stb  = 1'b0;
  logic [7:0]  ev_code = 8'h00;
  logic [23:1] addr;
  logic [5:0]  am;
  logic [1:0]  ds_n;
  logic        as_n, write_n, iack_n, s_oe, dtack_oe, ok, iackout_n, dtack_lvl;
  logic [15:0] m_data, s_data, bus;
  logic [7:1]  irq_oe, irq_lvl;
  logic [7:0]  d;
  int          failures        = 0;
  int          samples_checked = 0;
  efi_row_t    rows [14];

  assign bus = s_oe ? s_data : m_data;

  efi_filter_irq #(.DEPTH(4)) efi_filter_irq_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .base_jmp_i(BASE), .addr_i(addr), .am_i(am),
    .as_n_i(as_n), .ds_n_i(ds_n), .write_n_i(write_n), .iack_n_i(iack_n), .iackin_n_i(iack_n),
    .data_i(bus), .data_o(s_data), .data_oe_o(s_oe), .dtack_o(dtack_lvl), .dtack_oe_o(dtack_oe),
    .iackout_n_o(iackout_n), .irq_o(irq_lvl), .irq_oe_o(irq_oe), .ev_stb_i(ev_stb), .ev_code_i(ev_code));

  efi_vme_master efi_vme_master_inst (
    .mclk_i(mclk_i), .dtack_oe_i(dtack_oe), .data_i(bus), .addr_o(addr), .am_o(am),
    .as_n_o(as_n), .ds_n_o(ds_n), .write_n_o(write_n), .iack_n_o(iack_n), .data_o(m_data));

  task automatic test_done();
    $display("checked %0d failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk_data(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk_data

  task automatic chk_irq(input string n, input logic [7:1] e);
    chk_data(n, {1'b0, e}, {1'b0, irq_oe});
  endtask : chk_irq

  task automatic raw(input logic ack, input logic wr, input logic [1:0] ds, input logic [5:0] am,
                     input logic [23:1] a, input logic [7:0] wd);
    efi_vme_master_inst.cyc(ack, wr, ds, am, a, wd, d, ok);
  endtask : raw

  task automatic acc(input logic wr, input logic [13:0] off, input logic [7:0] wd);
    raw(1'b0, wr, 2'b10, efi_pkg::AM_SUPER, {BASE, off[13:1]}, wd);
  endtask : acc

  task automatic rdc(input string n, input logic [13:0] off, input logic [7:0] e);
    acc(1'b0, off, 8'h00);
    chk_data(n, e, d);
  endtask : rdc

  task automatic ev(input logic [7:0] c);
    @(negedge mclk_i);
    ev_stb  = 1'b1;
    ev_code = c;
    @(negedge mclk_i);
    ev_stb = 1'b0;
  endtask : ev

  initial
  begin
    forever #10 mclk_i = ~mclk_i;
  end

  initial
  begin
    repeat (5000) @(posedge mclk_i);
    failures++;
    test_done();
  end

  initial
  begin
    rows = '{{1'b0, efi_pkg::OFS_ROUTE, 16'h0000}, {1'b0, efi_pkg::OFS_VECTOR, 16'h0000},
             {1'b0, efi_pkg::OFS_FSTAT, 16'h0010}, {1'b1, efi_pkg::OFS_ROUTE, 16'h0300},
             {1'b0, efi_pkg::OFS_ROUTE, 16'h0003}, {1'b1, efi_pkg::OFS_VECTOR, 16'hA500},
             {1'b0, efi_pkg::OFS_VECTOR, 16'h00A5}, {1'b1, 14'h0815, 16'h0100},
             {1'b0, 14'h0815, 16'h0001}, {1'b1, 14'h0819, 16'h0100}, {1'b1, 14'h081D, 16'h0100},
             {1'b1, 14'h0821, 16'h0100}, {1'b0, 14'h0101, 16'h0000}, {1'b0, efi_pkg::OFS_STATUS, 16'h0000}};
    repeat (16) @(negedge mclk_i);
    chk_irq("irq in reset", 7'h00);
    chk_data("od drive", 8'h00, {dtack_lvl, irq_lvl});
    chk_data("pass idle", 8'h01, {7'h00, iackout_n});
    rst_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    foreach (rows[i])
    begin
      acc(rows[i].wr, rows[i].off, rows[i].wd);
      if (!rows[i].wr)
        chk_data("row", rows[i].ex, d);
    end
    $display("rows done");
    ev(8'h0B);
    chk_irq("off code", 7'h00);
    rdc("off fstat", efi_pkg::OFS_FSTAT, 8'h10);
    ev(8'h0A);
    chk_irq("first", 7'h04);
    ev(8'h0C);
    raw(1'b1, 1'b0, 2'b10, efi_pkg::AM_SUPER, 23'h2, 8'h00);
    chk_data("other level", 8'h00, {7'h00, ok});
    chk_data("passed on", 8'h00, {7'h00, iackout_n});
    raw(1'b1, 1'b0, 2'b10, efi_pkg::AM_SUPER, 23'h3, 8'h00);
    chk_data("vector", 8'hA5, d);
    chk_data("not passed", 8'h01, {7'h00, iackout_n});
    chk_irq("after ack", 7'h04);
    rdc("head", efi_pkg::OFS_STATUS, 8'h0A);
    chk_irq("released", 7'h00);
    ev(8'h0E);
    chk_irq("silent", 7'h00);
    rdc("second", efi_pkg::OFS_STATUS, 8'h0C);
    rdc("third", efi_pkg::OFS_STATUS, 8'h0E);
    $display("event test done");
    // Back to back strobes overrun the queue by two
    @(negedge mclk_i);
    ev_stb = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      ev_code = 8'h0A + 8'(2 * (i % 4));
      @(negedge mclk_i);
    end
    ev_stb = 1'b0;
    chk_irq("burst", 7'h04);
    rdc("full err", efi_pkg::OFS_FSTAT, 8'h21);
    rdc("err clear", efi_pkg::OFS_FSTAT, 8'h20);
    for (int i = 0; i < 4; i++)
      rdc("order", efi_pkg::OFS_STATUS, 8'h0A + 8'(2 * i));
    rdc("drained", efi_pkg::OFS_FSTAT, 8'h10);
    $display("queue test done");
    raw(1'b0, 1'b0, 2'b10, 6'h09, {BASE, 13'h0020}, 8'h00);
    chk_data("bad am", 8'h00, {7'h00, ok});
    raw(1'b0, 1'b0, 2'b10, efi_pkg::AM_USER, {BASE, 13'h0020}, 8'h00);
    chk_data("user am", 8'h03, d);
    raw(1'b0, 1'b0, 2'b10, efi_pkg::AM_SUPER, {~BASE, 13'h0020}, 8'h00);
    chk_data("bad base", 8'h00, {7'h00, ok});
    raw(1'b0, 1'b1, 2'b01, efi_pkg::AM_SUPER, {BASE, 13'h0020}, 8'h05);
    rdc("even wr", efi_pkg::OFS_ROUTE, 8'h03);
    raw(1'b0, 1'b0, 2'b01, efi_pkg::AM_SUPER, {BASE, 13'h0020}, 8'h00);
    chk_data("even rd", 8'h00, d);
    raw(1'b0, 1'b0, 2'b00, efi_pkg::AM_SUPER, {BASE, 13'h0020}, 8'h00);
    chk_data("word rd", 8'h03, d);
    $display("refusal test done");
    for (int r = 0; r < 8; r++)
    begin
      acc(1'b1, efi_pkg::OFS_ROUTE, 8'(r));
      acc(1'b0, efi_pkg::OFS_FCLEAR, 8'h00);
      acc(1'b0, efi_pkg::OFS_STATUS, 8'h00);
      ev(8'h0A);
      chk_irq("route", (r == 0) ? 7'h00 : 7'(1 << (r - 1)));
    end
    $display("route test done");
    // Mid-run reset with a request pending and route 7
    @(negedge mclk_i);
    rst_i = 1'b1;
    repeat (16) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk_irq("reset irq", 7'h00);
    rdc("reset route", efi_pkg::OFS_ROUTE, 8'h00);
    rdc("reset fstat", efi_pkg::OFS_FSTAT, 8'h10);
    $display("reset test done");
    test_done();
  end

endmodule : event_filter_interrupter_tb_top
